// *** hdl/mfs_cfg.svh ***
`ifndef MFS_CFG_SVH
`define MFS_CFG_SVH

// byte addresses inside the lower management page
`define MFS_ADDR_IRQ_STATUS   8'h03
`define MFS_ADDR_SUM_BANK0    8'h04
`define MFS_ADDR_SUM_BANK1    8'h05
`define MFS_ADDR_SUM_BANK2    8'h06
`define MFS_ADDR_SUM_BANK3    8'h07
`define MFS_ADDR_EVENT_FLAGS  8'h08
`define MFS_ADDR_SUPPLY_TEMP  8'h09
`define MFS_ADDR_AUX12        8'h0A
`define MFS_ADDR_AUX3_VENDOR  8'h0B
`define MFS_ADDR_RESERVED     8'h0C
`define MFS_ADDR_VENDOR_CUST  8'h0D

// field positions
`define MFS_BIT_STATE_CHANGE  0
`define MFS_BIT_FW_FAULT      1
`define MFS_BIT_CMD_BLOCK1    6
`define MFS_BIT_CMD_BLOCK2    7
`define MFS_BIT_IRQ_IDLE      0

// reset value and array sizes
`define MFS_FLAG_RESET        8'h00
`define MFS_NUM_BANKS         4
`define MFS_NUM_PAGES         5
`define MFS_NUM_FLAG_BYTES    4

`endif

// *** hdl/mfs_pkg.sv ***
package mfs_pkg;
    // threshold crossings of one monitor, in register bit order
    typedef struct packed {
        logic lo_warn;
        logic hi_warn;
        logic lo_alarm;
        logic hi_alarm;
    } mfs_mon_s;

    // all raw module-level conditions, one cycle or level each
    typedef struct packed {
        logic     cmd_block2_done;
        logic     cmd_block1_done;
        logic     fw_fault;
        mfs_mon_s supply;
        mfs_mon_s temp;
        mfs_mon_s aux_b;
        mfs_mon_s aux_a;
        mfs_mon_s vendor_mon;
        mfs_mon_s aux_c;
    } mfs_cond_s;

    // per-bank page flag presence: bit4 1Ah, 3 2Ch, 2 14h, 1 12h, 0 11h
    typedef logic [4:0] mfs_page_t;

    typedef enum {
        MFS_IDLE,
        MFS_READ
    } mfs_rd_e;
endpackage

// *** hdl/mfs_flag_latch.sv ***
`timescale 1ns/1ps
`include "mfs_cfg.svh"

module mfs_flag_latch (
    input  wire logic       mclk_i,
    input  wire logic       sys_rst_i,
    input  wire logic [7:0] set_i,
    input  wire logic       clr_i,
    output logic      [7:0] flags_o
);
    import mfs_pkg::*;

    // set wins over a read clear in the same cycle
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            flags_o <= `MFS_FLAG_RESET;
        end else begin
            flags_o <= (clr_i ? 8'h00 : flags_o) | set_i;
        end
    end
endmodule

// *** hdl/mfs_state_watch.sv ***
`timescale 1ns/1ps

module mfs_state_watch (
    input  wire logic       mclk_i,
    input  wire logic       sys_rst_i,
    input  wire logic [2:0] module_state_i,
    output logic            changed_o
);
    import mfs_pkg::*;

    logic [2:0] prev_state;
    logic       primed;

    // first sample after reset only primes, so reset itself is no change
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            prev_state <= 3'h0;
            primed     <= 1'b0;
        end else begin
            prev_state <= module_state_i;
            primed     <= 1'b1;
        end
    end

    assign changed_o = primed && (prev_state != module_state_i);
endmodule

// *** hdl/mfs_flag_summary.sv ***
`timescale 1ns/1ps
`include "mfs_cfg.svh"
// Function
// - one summary byte per bank at bytes 4 to 7, bits 7 to 5 reserved
// - summary bit is one while any flag of its bank and page is set
// - summary bits: 4 page 1Ah, 3 2Ch, 2 14h, 1 12h, 0 11h
// - reading summary never clears it; host reads underlying flag instead
// - all module flags zero after reset until a condition sets them; byte 13 shows vendor_custom_i directly, unlatched, so it is not zeroed
// - byte 8 bit 0 latches on any module state change
// - byte 8 bit 1 latches on main firmware self-supervision failure
// - byte 8 bits 7,6 latch command block 2,1 done; bits 5-2 reserved
// - byte 9 bits 7-4 supply lo warn, hi warn, lo alarm, hi alarm
// - byte 9 bits 3-0 temperature lo warn, hi warn, lo alarm, hi alarm
// - byte 10 holds aux 2 flags high nibble, aux 1 flags low nibble
// - byte 11 holds vendor monitor flags high nibble, aux 3 low nibble
// - warning or alarm flag sets when its monitor crosses its threshold
// - byte 12 reserved; byte 13 for vendor custom flags
// - module flag bytes exist only in paged memory model
// - byte 3 bit 0 reads one when interrupt not asserted, else zero

module mfs_flag_summary (
    input  wire logic                                   mclk_i,
    input  wire logic                                   sys_rst_i,
    // management read port: one-cycle strobe, data one cycle later
    input  wire logic                                   rd_stb_i,
    input  wire logic [7:0]                             rd_addr_i,
    output logic      [7:0]                             rd_data_o,
    output logic                                        rd_valid_o,
    // module model and status
    input  wire logic                                   paged_mode_i,
    input  wire logic [2:0]                             module_state_i,
    input  wire logic                                   irq_asserted_i,
    input  wire logic                                   cmd_block1_supported_i,
    input  wire logic                                   cmd_block2_supported_i,
    input  wire mfs_pkg::mfs_cond_s                     cond_i,
    input  wire logic [7:0]                             vendor_custom_i,
    // latched flags of the lane-level pages, per bank
    input  wire mfs_pkg::mfs_page_t [`MFS_NUM_BANKS-1:0] page_flags_i,
    output logic      [7:0]                             module_event_flags_o,
    output logic      [7:0]                             supply_temp_flags_o,
    output logic      [7:0]                             aux1_aux2_flags_o,
    output logic      [7:0]                             aux3_custom_mon_flags_o
);
    import mfs_pkg::*;

    logic [7:0]  flag_set [`MFS_NUM_FLAG_BYTES];
    logic [7:0]  flag_val [`MFS_NUM_FLAG_BYTES];
    logic [`MFS_NUM_FLAG_BYTES-1:0] flag_clr;
    logic [7:0]  flag_summary [`MFS_NUM_BANKS];
    logic        state_changed;
    logic [7:0]  next_rd_data;
    logic        irq_pin_idle_status;

    mfs_state_watch u_state_watch (
        .mclk_i         (mclk_i),
        .sys_rst_i      (sys_rst_i),
        .module_state_i (module_state_i),
        .changed_o      (state_changed)
    );

    // set terms per byte, in register bit order
    always_comb begin
        flag_set[0] = 8'h00;
        flag_set[0][`MFS_BIT_CMD_BLOCK2]   = cond_i.cmd_block2_done
                                             && cmd_block2_supported_i;
        flag_set[0][`MFS_BIT_CMD_BLOCK1]   = cond_i.cmd_block1_done
                                             && cmd_block1_supported_i;
        flag_set[0][`MFS_BIT_FW_FAULT]     = cond_i.fw_fault;
        flag_set[0][`MFS_BIT_STATE_CHANGE] = state_changed;
        flag_set[1] = {cond_i.supply, cond_i.temp};
        flag_set[2] = {cond_i.aux_b, cond_i.aux_a};
        flag_set[3] = {cond_i.vendor_mon, cond_i.aux_c};
    end

    // flat memory modules hold no module flags at all
    genvar gi;
    generate
        for (gi = 0; gi < `MFS_NUM_FLAG_BYTES; gi++) begin : g_flag
            assign flag_clr[gi] = rd_stb_i && paged_mode_i
                && (rd_addr_i == `MFS_ADDR_EVENT_FLAGS + 8'(gi));
            mfs_flag_latch u_latch (
                .mclk_i    (mclk_i),
                .sys_rst_i (sys_rst_i),
                .set_i     (paged_mode_i ? flag_set[gi] : 8'h00),
                .clr_i     (flag_clr[gi]),
                .flags_o   (flag_val[gi])
            );
        end
        for (gi = 0; gi < `MFS_NUM_BANKS; gi++) begin : g_sum
            // straight copy of the page flag presence bits, no own state to clear
            assign flag_summary[gi] = {3'h0,
                                       page_flags_i[gi]};
        end
    endgenerate

    assign irq_pin_idle_status = !irq_asserted_i;

    always_comb begin
        next_rd_data = 8'h00;
        case (rd_addr_i)
            `MFS_ADDR_IRQ_STATUS:  next_rd_data[`MFS_BIT_IRQ_IDLE] = irq_pin_idle_status;
            `MFS_ADDR_SUM_BANK0:   next_rd_data = flag_summary[0];
            `MFS_ADDR_SUM_BANK1:   next_rd_data = flag_summary[1];
            `MFS_ADDR_SUM_BANK2:   next_rd_data = flag_summary[2];
            `MFS_ADDR_SUM_BANK3:   next_rd_data = flag_summary[3];
            `MFS_ADDR_EVENT_FLAGS: next_rd_data = paged_mode_i ? flag_val[0] : 8'h00;
            `MFS_ADDR_SUPPLY_TEMP: next_rd_data = paged_mode_i ? flag_val[1] : 8'h00;
            `MFS_ADDR_AUX12:       next_rd_data = paged_mode_i ? flag_val[2] : 8'h00;
            `MFS_ADDR_AUX3_VENDOR: next_rd_data = paged_mode_i ? flag_val[3] : 8'h00;
            `MFS_ADDR_RESERVED:    next_rd_data = 8'h00;
            `MFS_ADDR_VENDOR_CUST: next_rd_data = paged_mode_i ? vendor_custom_i
                                                               : 8'h00;
            default:               next_rd_data = 8'h00;
        endcase
    end

    // data sampled before the clear lands, so the host sees the latched bits
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rd_data_o  <= 8'h00;
            rd_valid_o <= 1'b0;
        end else begin
            rd_valid_o <= rd_stb_i;
            if (rd_stb_i) begin
                rd_data_o <= next_rd_data;
            end
        end
    end

    assign module_event_flags_o    = flag_val[0];
    assign supply_temp_flags_o     = flag_val[1];
    assign aux1_aux2_flags_o       = flag_val[2];
    assign aux3_custom_mon_flags_o = flag_val[3];
endmodule

// *** testbench/mfs_flag_summary_props.sv ***
`timescale 1ns/1ps
`include "mfs_cfg.svh"
module mfs_chk (
    input wire logic                mclk_i,
    input wire logic                sys_rst_i,
    input wire logic                rd_stb_i,
    input wire logic          [7:0] rd_addr_i,
    input wire logic          [7:0] rd_data_o,
    input wire logic                paged_mode_i,
    input wire logic          [2:0] module_state_i,
    input wire logic                irq_asserted_i,
    input wire mfs_pkg::mfs_cond_s  cond_i,
    input wire mfs_pkg::mfs_page_t [`MFS_NUM_BANKS-1:0] page_flags_i,
    input wire logic          [7:0] module_event_flags_o,
    input wire logic          [7:0] supply_temp_flags_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    // idle cycles map to an unmapped address so only p_lat and p_st, which match no single address, fire
    wire [7:0] rda = rd_stb_i ? rd_addr_i : 8'hFF;
    wire       sum_rd = rda[7:2] == 6'h01;
    wire [7:0] st_set = {cond_i.supply, cond_i.temp};
    property p_rsv; sum_rd |=> rd_data_o[7:5] == 3'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("summary reserved bit set");
    property p_sum; sum_rd |=> rd_data_o[4:0] == $past(page_flags_i[rda[1:0]]); endproperty
    a_sum: assert property (p_sum) else $error("summary byte wrong");
    property p_irq; rda == 8'h03 |=> rd_data_o == {7'h00, !$past(irq_asserted_i)}; endproperty
    a_irq: assert property (p_irq) else $error("irq status wrong");
    property p_r12; rda == 8'h0C |=> rd_data_o == 8'h00; endproperty
    a_r12: assert property (p_r12) else $error("reserved byte nonzero");
    property p_flat; !paged_mode_i && rda inside {[8'h08:8'h0D]}
        |=> rd_data_o == 8'h00; endproperty
    a_flat: assert property (p_flat) else $error("flat mode flag byte nonzero");
    property p_st; paged_mode_i && $changed(module_state_i) && !$past(sys_rst_i)
        |=> module_event_flags_o[0]; endproperty
    a_st: assert property (p_st) else $error("state change not latched");
    property p_clr; rda == 8'h09 && paged_mode_i && st_set == 8'h00
        |=> supply_temp_flags_o == 8'h00; endproperty
    a_clr: assert property (p_clr) else $error("read did not clear");
    property p_lat; paged_mode_i && rda != 8'h09
        |=> supply_temp_flags_o == ($past(supply_temp_flags_o) | $past(st_set)); endproperty
    a_lat: assert property (p_lat) else $error("supply temp latch wrong");
endmodule
bind mfs_flag_summary mfs_chk i_chk (.mclk_i, .sys_rst_i, .rd_stb_i, .rd_addr_i, .rd_data_o,
    .paged_mode_i, .module_state_i, .irq_asserted_i, .cond_i, .page_flags_i,
    .module_event_flags_o, .supply_temp_flags_o);

// *** testbench/mfs_host.sv ***
`timescale 1ns/1ps
module mfs_host (
    input  wire logic       mclk_i,
    input  wire logic [7:0] rd_data_i,
    input  wire logic       rd_valid_i,
    output logic            rd_stb_o,
    output logic      [7:0] rd_addr_o
);
    initial begin
        rd_stb_o = 1'b0;
        rd_addr_o = 8'h00;
    end
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        rd_stb_o <= 1'b1;
        rd_addr_o <= a;
        @(posedge mclk_i);
        // request taken at this edge; the answer stands through the next cycle
        rd_stb_o <= 1'b0;
        // released address flips so a stale one is never mistaken for held
        rd_addr_o <= ~a;
        @(posedge mclk_i);
        d = rd_valid_i ? rd_data_i : 8'hXX;
    endtask
endmodule

// *** testbench/mfs_flag_summary_tb.sv ***
`timescale 1ns/1ps
module mfs_flag_summary_tb;
    import mfs_pkg::*;
    logic            mclk_i, sys_rst_i, rd_stb_i, rd_valid_o, paged_mode_i, irq_asserted_i;
    logic            cmd_block1_supported_i, cmd_block2_supported_i;
    logic      [7:0] rd_addr_i, rd_data_o, vendor_custom_i;
    logic      [2:0] module_state_i;
    mfs_cond_s       cond_i;
    mfs_page_t [3:0] page_flags_i;
    int              bad_count, checks_done;
    logic      [7:0] flag_out [4];
    mfs_flag_summary i_dut (.mclk_i, .sys_rst_i, .rd_stb_i, .rd_addr_i, .rd_data_o, .rd_valid_o,
        .paged_mode_i, .module_state_i, .irq_asserted_i, .cmd_block1_supported_i,
        .cmd_block2_supported_i, .cond_i, .vendor_custom_i, .page_flags_i,
        .module_event_flags_o(flag_out[0]), .supply_temp_flags_o(flag_out[1]),
        .aux1_aux2_flags_o(flag_out[2]), .aux3_custom_mon_flags_o(flag_out[3]));
    mfs_host i_host (.mclk_i, .rd_data_i(rd_data_o), .rd_valid_i(rd_valid_o),
        .rd_stb_o(rd_stb_i), .rd_addr_o(rd_addr_i));
    task automatic cmp(input string what, input logic [7:0] e, input logic [7:0] s);
        checks_done++;
        if (s !== e) begin
            $display("[FAIL] %s exp %h got %h", what, e, s);
            bad_count++;
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        i_host.read(a, d);
        cmp($sformatf("byte %h", a), e, d);
    endtask
    task automatic drv(input logic [26:0] c);
        @(posedge mclk_i);
        cond_i <= c;
    endtask
    task automatic t_reset;
        for (int i = 8; i < 12; i++) rdc(8'(i), 8'h00);
        rdc(8'h0C, 8'h00);
        rdc(8'h0D, 8'h5A);
        rdc(8'h03, 8'h01);
        @(posedge mclk_i);
        irq_asserted_i <= 1'b1;
        rdc(8'h03, 8'h00);
    endtask
    task automatic t_sum;
        for (int b = 0; b < 4; b++) page_flags_i[b] <= 5'h1F - 5'(b);
        for (int b = 0; b < 4; b++) begin
            rdc(8'h04 + 8'(b), 8'h1F - 8'(b));
            rdc(8'h04 + 8'(b), 8'h1F - 8'(b));
        end
        @(posedge mclk_i);
        page_flags_i[1] <= 5'h00;
        rdc(8'h05, 8'h00);
    endtask
    task automatic t_mon;
        logic [7:0] exp [4] = '{8'h42, 8'h81, 8'h42, 8'h24};
        drv(27'h7814224);
        drv(27'h0000000);
        @(posedge mclk_i);
        for (int i = 0; i < 4; i++) begin
            cmp($sformatf("flags_o %0d", i), exp[i], flag_out[i]);
        end
        for (int i = 0; i < 4; i++) begin
            rdc(8'h08 + 8'(i), exp[i]);
            rdc(8'h08 + 8'(i), 8'h00);
        end
        drv(27'h0000001);
        rdc(8'h0B, 8'h01);
        rdc(8'h0B, 8'h01);
        drv(27'h0000000);
        module_state_i <= 3'h3;
        rdc(8'h08, 8'h01);
        // the bit outlives its condition until the host reads it
        rdc(8'h0B, 8'h01);
        rdc(8'h0B, 8'h00);
        cmd_block2_supported_i <= 1'b1;
        drv(27'h4000000);
        drv(27'h0000000);
        rdc(8'h08, 8'h80);
    endtask
    task automatic t_flat;
        @(posedge mclk_i);
        paged_mode_i <= 1'b0;
        drv(27'h7FFFFFF);
        drv(27'h0000000);
        for (int i = 8; i < 14; i++) rdc(8'(i), 8'h00);
        // back in paged mode nothing may have latched meanwhile
        paged_mode_i <= 1'b1;
        for (int i = 8; i < 12; i++) rdc(8'(i), 8'h00);
    endtask
    task automatic t_rst;
        drv(27'h0800000);
        drv(27'h0000000);
        @(posedge mclk_i);
        cmp("flags_o 1", 8'h80, flag_out[1]);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        rdc(8'h09, 8'h00);
    endtask
    task automatic tally_and_finish;
        if (bad_count == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end
    initial begin
        #50000;
        bad_count++;
        tally_and_finish();
    end
    initial begin
        {sys_rst_i, paged_mode_i, cmd_block1_supported_i} = 3'h7;
        {irq_asserted_i, cmd_block2_supported_i} = 2'h0;
        {module_state_i, cond_i, page_flags_i} = '0;
        vendor_custom_i = 8'h5A;
        repeat (4) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        t_reset();
        t_sum();
        t_mon();
        t_flat();
        t_rst();
        tally_and_finish();
    end
endmodule
